/* weld_current_range_mode_config.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module weld_current_range_mode_config (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire weld_range_pkg::bus_type bus,
  output logic [15:0] rdata,
  // sensor side
  input wire weld_range_pkg::meas_type meas,
  // regulator and panel side
  output weld_range_pkg::cfg_type cfg,
  output logic ccActive,
  output logic [15:0] displayData,
  output logic displayIsRms,
  output logic errHi,
  output logic errLo,
  output logic irq
);

  typedef struct packed {
    weld_range_pkg::phase_type phase;
    logic [7:0] mode;
    logic [15:0] range;
    logic [15:0] current;
    logic [15:0] loLim;
    logic [15:0] hiLim;
    logic [7:0] procOpt;
    logic [15:0] nccPercent;
    logic [15:0] lastRms;
    logic showRms;
    logic [15:0] display;
    logic hi;
    logic lo;
    logic [weld_range_pkg::ST_WIDTH-1:0] status;
    logic [weld_range_pkg::ST_WIDTH-1:0] mask;
    logic [15:0] rdata;
  } state_type;

  state_type cur;
  state_type next_cur;

  logic isAuto;
  logic isManual;
  logic isKnown;
  logic isRegulate;
  logic newAuto;
  logic newManual;
  logic inTable;
  logic wdataBcd;
  logic rmsBcd;
  logic [weld_range_pkg::ST_WIDTH-1:0] events;
  logic refused;
  logic wrStatus;

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  weld_mode_decode u_held_mode (
    .code(cur.mode),
    .autoRange(isAuto),
    .manualRange(isManual),
    .regulate(isRegulate)
  );

  weld_mode_decode u_new_mode (
    .code(bus.wdata[7:0]),
    .autoRange(newAuto),
    .manualRange(newManual),
    .regulate()
  );

  assign isKnown = isAuto || isManual;

  // lookup of the written range value among the sixteen full scales
  weld_range_lookup #(
    .MISS_INDEX(4'h0)
  ) u_new_range (
    .value(bus.wdata),
    .hit(inTable),
    .index()
  );

  // digit checks of the written value and of the measured rms
  weld_bcd_check u_new_digits (
    .value(bus.wdata),
    .valid(wdataBcd)
  );

  weld_bcd_check u_rms_digits (
    .value(meas.rms),
    .valid(rmsBcd)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration outputs

  logic [3:0] heldIndex;

  weld_range_lookup #(
    .MISS_INDEX(weld_range_pkg::RANGE_TOP_INDEX)
  ) u_held_range (
    .value(cur.range),
    .hit(),
    .index(heldIndex)
  );

  always_comb begin
    cfg.regulate = isRegulate;
    cfg.monitor = isKnown;
    cfg.needSetup = isAuto;
    if (isAuto) begin
      cfg.unitsKa = (cur.range != weld_range_pkg::RANGE_PERCENT);
    end else begin
      cfg.unitsKa = (cur.mode == weld_range_pkg::MODE_MAN_REG);
    end
    cfg.rangeIndex = heldIndex;
    cfg.rangeScale = cur.range;
  end

  assign ccActive = (cur.phase == weld_range_pkg::ST_CONST_CURRENT);
  assign rdata = cur.rdata;
  assign displayData = cur.display;
  assign displayIsRms = cur.showRms;
  assign errHi = cur.hi;
  assign errLo = cur.lo;
  assign irq = |(cur.status & cur.mask);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_cur = cur;
    refused = 1'b0;
    events = '0;
    wrStatus = bus.wr && (bus.addr == weld_range_pkg::ADDR_STATUS);

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        weld_range_pkg::ADDR_MODE: begin
          next_cur.mode = bus.wdata[7:0];
          if (newAuto) begin
            next_cur.phase = weld_range_pkg::ST_LEARNING;
          end else if (newManual) begin
            next_cur.phase = weld_range_pkg::ST_CONST_CURRENT;
          end else begin
            next_cur.phase = weld_range_pkg::ST_NO_CC;
          end
        end
        weld_range_pkg::ADDR_RANGE: begin
          if (isAuto && wdataBcd) begin
            next_cur.range = bus.wdata;
          end else if (isManual && inTable) begin
            next_cur.range = bus.wdata;
          end else begin
            refused = 1'b1;
          end
        end
        weld_range_pkg::ADDR_CURRENT: begin
          if (!wdataBcd) begin
            refused = 1'b1;
          end else if (cur.mode == weld_range_pkg::MODE_MAN_MON &&
              bus.wdata > weld_range_pkg::PCT_MAX) begin
            refused = 1'b1;
          end else begin
            next_cur.current = bus.wdata;
            if (cur.phase == weld_range_pkg::ST_NO_CC) begin
              next_cur.nccPercent = bus.wdata;
            end
          end
        end
        weld_range_pkg::ADDR_LOLIM: begin
          if (wdataBcd) begin
            next_cur.loLim = bus.wdata;
          end else begin
            refused = 1'b1;
          end
        end
        weld_range_pkg::ADDR_HILIM: begin
          if (wdataBcd) begin
            next_cur.hiLim = bus.wdata;
          end else begin
            refused = 1'b1;
          end
        end
        weld_range_pkg::ADDR_PROCOPT: begin
          next_cur.procOpt = bus.wdata[7:0];
        end
        weld_range_pkg::ADDR_MASK: begin
          next_cur.mask = bus.wdata[weld_range_pkg::ST_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // learning setup finished
    if (meas.setupDone && cur.phase == weld_range_pkg::ST_LEARNING) begin
      next_cur.phase = weld_range_pkg::ST_CONST_CURRENT;
      next_cur.nccPercent = 16'h0000;
      if (cur.range != weld_range_pkg::RANGE_PERCENT && rmsBcd) begin
        next_cur.range = meas.rms;
      end
      events[weld_range_pkg::ST_SETUP] = 1'b1;
    end

    // end of a weld sequence
    if (meas.seqEnd) begin
      events[weld_range_pkg::ST_SEQEND] = 1'b1;
      if (isKnown) begin
        next_cur.lastRms = meas.rms;
        next_cur.showRms = 1'b1;
      end
      next_cur.hi = 1'b0;
      next_cur.lo = 1'b0;
      if (cur.procOpt == weld_range_pkg::PROC_LIMITS && isKnown) begin
        if (meas.rms > cur.hiLim) begin
          next_cur.hi = 1'b1;
          events[weld_range_pkg::ST_HI] = 1'b1;
        end
        if (meas.rms < cur.loLim) begin
          next_cur.lo = 1'b1;
          events[weld_range_pkg::ST_LO] = 1'b1;
        end
      end
    end else if (bus.wr && bus.addr == weld_range_pkg::ADDR_CURRENT) begin
      next_cur.showRms = 1'b0;
    end

    events[weld_range_pkg::ST_REFUSED] = refused;

    // sticky status, write one to clear, a new event wins
    if (wrStatus) begin
      next_cur.status = (cur.status &
        ~bus.wdata[weld_range_pkg::ST_WIDTH-1:0]) | events;
    end else begin
      next_cur.status = cur.status | events;
    end

    next_cur.display = next_cur.showRms ? next_cur.lastRms :
      next_cur.current;

    // read data, valid the cycle after the strobe
    next_cur.rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        weld_range_pkg::ADDR_MODE: next_cur.rdata = {8'h00, cur.mode};
        weld_range_pkg::ADDR_RANGE: next_cur.rdata = cur.range;
        weld_range_pkg::ADDR_CURRENT: next_cur.rdata = cur.current;
        weld_range_pkg::ADDR_LOLIM: next_cur.rdata = cur.loLim;
        weld_range_pkg::ADDR_HILIM: next_cur.rdata = cur.hiLim;
        weld_range_pkg::ADDR_PROCOPT: next_cur.rdata = {8'h00, cur.procOpt};
        weld_range_pkg::ADDR_STATUS: begin
          next_cur.rdata = {11'h000, cur.status};
        end
        weld_range_pkg::ADDR_MASK: begin
          next_cur.rdata = {11'h000, cur.mask};
        end
        weld_range_pkg::ADDR_RMS: next_cur.rdata = cur.lastRms;
        weld_range_pkg::ADDR_STATE: begin
          next_cur.rdata = {7'h00, cfg.rangeIndex, cur.lo, cur.hi,
            cur.phase};
        end
        weld_range_pkg::ADDR_NCCPCT: next_cur.rdata = cur.nccPercent;
        default: next_cur.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.phase <= weld_range_pkg::ST_NO_CC;
      cur.mode <= weld_range_pkg::RST_MODE;
      cur.range <= weld_range_pkg::RST_RANGE;
      cur.current <= weld_range_pkg::RST_CURRENT;
      cur.loLim <= weld_range_pkg::RST_LOLIM;
      cur.hiLim <= weld_range_pkg::RST_HILIM;
      cur.procOpt <= weld_range_pkg::RST_PROCOPT;
      cur.nccPercent <= weld_range_pkg::RST_CURRENT;
      cur.lastRms <= 16'h0000;
      cur.showRms <= 1'b0;
      cur.display <= 16'h0000;
      cur.hi <= 1'b0;
      cur.lo <= 1'b0;
      cur.status <= '0;
      cur.mask <= '0;
      cur.rdata <= 16'h0000;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////
// mode code classes, shared by the held and the written code

module weld_mode_decode (
  // two digit mode code
  input wire logic [7:0] code,
  // decoded classes
  output logic autoRange,
  output logic manualRange,
  output logic regulate
);

  always_comb begin
    autoRange = (code == weld_range_pkg::MODE_HALL_REG) ||
      (code == weld_range_pkg::MODE_HALL_MON) ||
      (code == weld_range_pkg::MODE_ROGO_REG) ||
      (code == weld_range_pkg::MODE_ROGO_MON);
    manualRange = (code == weld_range_pkg::MODE_MAN_REG) ||
      (code == weld_range_pkg::MODE_MAN_MON);
    regulate = (code == weld_range_pkg::MODE_HALL_REG) ||
      (code == weld_range_pkg::MODE_ROGO_REG) ||
      (code == weld_range_pkg::MODE_MAN_REG);
  end

endmodule

////////////////////////////////////////////////////////////////////////
// full-scale table lookup; a miss reports the given index

module weld_range_lookup #(
  parameter logic [3:0] MISS_INDEX = 4'h0
) (
  // value to look up
  input wire logic [15:0] value,
  // match and its table index
  output logic hit,
  output logic [3:0] index
);

  always_comb begin
    hit = 1'b0;
    index = MISS_INDEX;
    for (int i = 0; i < 16; i++) begin
      if (value == weld_range_pkg::RANGE_TABLE[i]) begin
        hit = 1'b1;
        index = 4'(i);
      end
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////
// every four-bit digit of a packed decimal value is 0 to 9

module weld_bcd_check #(
  parameter int DIGITS = 4
) (
  // packed decimal value
  input wire logic [4*DIGITS-1:0] value,
  // all digits legal
  output logic valid
);

  logic [DIGITS-1:0] digitOk;

  for (genvar g = 0; g < DIGITS; g++) begin : gen_digit
    assign digitOk[g] = (value[4*g+:4] < 4'ha);
  end

  assign valid = &digitOk;

endmodule

/* weld_range_pkg.sv */
package weld_range_pkg;

  // register offsets
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_RANGE = 4'h1;
  localparam logic [3:0] ADDR_CURRENT = 4'h2;
  localparam logic [3:0] ADDR_LOLIM = 4'h3;
  localparam logic [3:0] ADDR_HILIM = 4'h4;
  localparam logic [3:0] ADDR_PROCOPT = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  localparam logic [3:0] ADDR_RMS = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'h9;
  localparam logic [3:0] ADDR_NCCPCT = 4'ha;

  // mode codes, two bcd digits
  localparam logic [7:0] MODE_HALL_REG = 8'h20;
  localparam logic [7:0] MODE_HALL_MON = 8'h21;
  localparam logic [7:0] MODE_ROGO_REG = 8'h30;
  localparam logic [7:0] MODE_ROGO_MON = 8'h31;
  localparam logic [7:0] MODE_MAN_REG = 8'h32;
  localparam logic [7:0] MODE_MAN_MON = 8'h33;
  localparam logic [7:0] PROC_LIMITS = 8'h12;

  // four digit values, and the one digit index of the top table entry
  localparam logic [15:0] RANGE_PERCENT = 16'h0099;
  localparam logic [15:0] RANGE_LARGEST = 16'h9999;
  localparam logic [15:0] PCT_MAX = 16'h0099;
  localparam logic [3:0] RANGE_TOP_INDEX = 4'hf;

  // reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_RANGE = 16'h9999;
  localparam logic [15:0] RST_CURRENT = 16'h0000;
  localparam logic [15:0] RST_LOLIM = 16'h0000;
  localparam logic [15:0] RST_HILIM = 16'h9999;
  localparam logic [7:0] RST_PROCOPT = 8'h00;

  // status and mask bit positions
  localparam int ST_SETUP = 0;
  localparam int ST_SEQEND = 1;
  localparam int ST_HI = 2;
  localparam int ST_LO = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_WIDTH = 5;

  // the sixteen manual full-scale values, index 0 is the smallest
  localparam logic [15:0][15:0] RANGE_TABLE = {
    16'h9999, 16'h9000, 16'h8000, 16'h7000,
    16'h6000, 16'h5000, 16'h4000, 16'h3000,
    16'h2000, 16'h1000, 16'h0800, 16'h0600,
    16'h0500, 16'h0400, 16'h0300, 16'h0200};

  typedef enum logic [2:0] {
    ST_NO_CC = 3'b001,
    ST_LEARNING = 3'b010,
    ST_CONST_CURRENT = 3'b100
  } phase_type;

  // what the sensor side reports
  typedef struct packed {
    logic seqEnd;
    logic setupDone;
    logic [15:0] rms;
  } meas_type;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_type;

  // regulator configuration towards the firing logic
  typedef struct packed {
    logic regulate;
    logic monitor;
    logic needSetup;
    logic unitsKa;
    logic [3:0] rangeIndex;
    logic [15:0] rangeScale;
  } cfg_type;

  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) &&
      (v[11:8] < 4'ha) && (v[15:12] < 4'ha);
  endfunction

endpackage

/* weld_range_checker_asserts.sv */
`timescale 1ns/1ns
module weld_range_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire weld_range_pkg::bus_type bus,
  input wire logic [15:0] rdata,
  // sensor and panel side
  input wire weld_range_pkg::meas_type meas,
  input wire weld_range_pkg::cfg_type cfg,
  input wire logic ccActive,
  input wire logic [15:0] displayData,
  input wire logic displayIsRms,
  input wire logic errHi,
  input wire logic errLo,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic modeWr;
  logic learn;
  logic rmsBcd;
  assign modeWr = bus.wr && bus.addr == 4'h0;
  assign learn = meas.setupDone && cfg.needSetup && !ccActive && !bus.wr;
  assign rmsBcd = (meas.rms[3:0] < 4'ha) && (meas.rms[7:4] < 4'ha) &&
    (meas.rms[11:8] < 4'ha) && (meas.rms[15:12] < 4'ha);
  //////////////////////////////////////////////////////////////
  AST_REGULATE: assert property (
    modeWr |=> cfg.regulate ==
    ($past(bus.wdata[7:0]) inside {8'h20, 8'h30, 8'h32}))
    else $error("regulate wrong");
  AST_AUTO: assert property (
    modeWr && bus.wdata[7:0] inside {8'h20, 8'h21, 8'h30, 8'h31}
    |=> cfg.needSetup && cfg.monitor && !ccActive)
    else $error("auto mode wrong");
  AST_MANUAL: assert property (
    modeWr && bus.wdata[7:0] inside {8'h32, 8'h33} |=> ccActive &&
    !cfg.needSetup && cfg.unitsKa == ($past(bus.wdata[7:0]) == 8'h32))
    else $error("manual mode wrong");
  AST_UNITS: assert property (
    cfg.needSetup |-> cfg.unitsKa == (cfg.rangeScale != 16'h0099))
    else $error("units wrong");
  AST_LARGEST: assert property (
    cfg.rangeScale == 16'h9999 |-> cfg.rangeIndex == 4'hf)
    else $error("largest range wrong");
  AST_SHOW_RMS: assert property (
    meas.seqEnd && cfg.monitor |=>
    displayIsRms && displayData == $past(meas.rms))
    else $error("rms not shown");
  AST_ERR_HOLD: assert property (
    !meas.seqEnd |=> $stable(errHi) && $stable(errLo))
    else $error("error flags moved");
  AST_SETUP_CC: assert property (
    learn |=> ccActive)
    else $error("no constant current");
  AST_LEARN: assert property (
    learn && cfg.unitsKa |=> cfg.rangeScale ==
    ($past(rmsBcd) ? $past(meas.rms) : $past(cfg.rangeScale)))
    else $error("range not learned");
endmodule

bind weld_current_range_mode_config weld_range_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .meas(meas), .cfg(cfg), .ccActive(ccActive),
  .displayData(displayData), .displayIsRms(displayIsRms),
  .errHi(errHi), .errLo(errLo), .irq(irq));

/* weld_sensor_model.sv */
`timescale 1ns/1ns
module weld_sensor_model (
  // clock
  input wire logic ref_clk,
  // sensor output
  output weld_range_pkg::meas_type meas
);
  initial meas = '0;
  // one cycle pulse; rms is inverted once released
  task automatic pulse(input logic s, input logic d, input logic [15:0] v);
    @(posedge ref_clk);
    meas <= '{seqEnd: s, setupDone: d, rms: v};
    @(posedge ref_clk);
    meas <= '{seqEnd: 1'b0, setupDone: 1'b0, rms: ~v};
    #1;
  endtask
endmodule

/* tb_weld_current_range_mode_config.sv */
`timescale 1ns/1ns
module tb_weld_current_range_mode_config;
  logic ref_clk;
  logic rst_n;
  weld_range_pkg::bus_type bus;
  logic [15:0] rdata;
  weld_range_pkg::meas_type meas;
  weld_range_pkg::cfg_type cfg;
  logic ccActive;
  logic [15:0] displayData;
  logic displayIsRms;
  logic errHi;
  logic errLo;
  logic irq;
  int failCount;
  int nChecks;
  logic [3:0] adr [9];
  logic [15:0] rstVal [9];
  logic [7:0] codes [7];
  logic [4:0] flags [7];

  weld_current_range_mode_config u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .meas(meas), .cfg(cfg), .ccActive(ccActive),
    .displayData(displayData), .displayIsRms(displayIsRms),
    .errHi(errHi), .errLo(errLo), .irq(irq));
  weld_sensor_model u_sensor (.ref_clk(ref_clk), .meas(meas));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [3:0] a, input logic [15:0] d,
                     input logic w, input logic r);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge ref_clk);
    bus <= '0;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    acc(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    acc(a, 16'h0000, 1'b0, 1'b1);
    chk(rdata, exp);
  endtask
  task automatic flg(input logic [4:0] e);
    chk({11'h000, cfg.regulate, cfg.monitor, cfg.needSetup, cfg.unitsKa,
         ccActive}, {11'h000, e});
  endtask
  task automatic evt(input logic [3:0] e);
    chk({12'h000, displayIsRms, errHi, errLo, irq}, {12'h000, e});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failCount++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    failCount = 0;
    nChecks = 0;
    adr = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
    rstVal = '{16'h0, 16'h9999, 16'h0, 16'h0, 16'h9999, 16'h0, 16'h0,
               16'h0, 16'h0};
    codes = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h32, 8'h33, 8'h12};
    flags = '{5'h1e, 5'h0e, 5'h1e, 5'h0e, 5'h1b, 5'h09, 5'h00};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(adr[i], rstVal[i]);
    end
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, {8'h00, codes[i]});
      flg(flags[i]);
    end
    $display("test modes done");
    wr(4'h0, 16'h0033);
    wr(4'h1, 16'h3000);
    chk({12'h000, cfg.rangeIndex}, 16'h0008);
    wr(4'h1, 16'h1234);
    rd(4'h1, 16'h3000);
    rd(4'h6, 16'h0010);
    wr(4'h6, 16'h001f);
    wr(4'h1, 16'h9999);
    chk({12'h000, cfg.rangeIndex}, 16'h000f);
    chk(cfg.rangeScale, 16'h9999);
    wr(4'h0, 16'h0012);
    wr(4'h1, 16'h2000);
    rd(4'h1, 16'h9999);
    $display("test ranges done");
    wr(4'h0, 16'h0033);
    wr(4'h2, 16'h0100);
    rd(4'h2, 16'h0000);
    wr(4'h2, 16'h0099);
    rd(4'h2, 16'h0099);
    wr(4'h3, 16'h1000);
    wr(4'h4, 16'h2000);
    wr(4'h4, 16'h12a0);
    rd(4'h4, 16'h2000);
    $display("test settings done");
    wr(4'h5, 16'h0012);
    wr(4'h7, 16'h0004);
    wr(4'h6, 16'h001f);
    u_sensor.pulse(1'b1, 1'b0, 16'h2500);
    evt(4'hd);
    chk(displayData, 16'h2500);
    rd(4'h8, 16'h2500);
    wr(4'h6, 16'h0004);
    evt(4'hc);
    u_sensor.pulse(1'b1, 1'b0, 16'h0500);
    evt(4'ha);
    wr(4'h2, 16'h0050);
    evt(4'h2);
    chk(displayData, 16'h0050);
    wr(4'h5, 16'h0000);
    u_sensor.pulse(1'b1, 1'b0, 16'h3000);
    evt(4'h8);
    chk(displayData, 16'h3000);
    $display("test monitor done");
    wr(4'h0, 16'h0012);
    wr(4'h2, 16'h0055);
    rd(4'ha, 16'h0055);
    u_sensor.pulse(1'b1, 1'b0, 16'h7777);
    chk(displayData, 16'h0055);
    wr(4'h0, 16'h0020);
    wr(4'h1, 16'h0099);
    flg(5'h1c);
    u_sensor.pulse(1'b0, 1'b1, 16'h4321);
    rd(4'h1, 16'h0099);
    wr(4'h0, 16'h0031);
    wr(4'h1, 16'h5000);
    u_sensor.pulse(1'b0, 1'b1, 16'h4321);
    flg(5'h0f);
    rd(4'h1, 16'h4321);
    rd(4'ha, 16'h0000);
    rd(4'h9, 16'h01e4);
    $display("test setup done");
    end_of_test;
  end
endmodule
